// ==== dv/ps2s_chk.sv ====
// Purpose: Port checks of the PS/2 channel status logic
// Assumes: Bound into ps2s_top, word-aligned byte addresses
// Notes:   Enable and mask are shadowed from bus writes
`timescale 1ns/100ps
`include "ps2s_cfg.svh"
module ps2s_chk #(
  parameter int unsigned START_CYC = 250000,
  parameter int unsigned FRAME_CYC = 20000
) (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Lines and interrupt
  input wire logic        ps2_clk_i,
  input wire logic        ps2_clk_o,
  input wire logic        ps2_clk_oe_o,
  input wire logic        ps2_dat_i,
  input wire logic        ps2_dat_o,
  input wire logic        ps2_dat_oe_o,
  input wire logic        irq_o
);
  logic       en_r;
  logic [7:0] mask_r;
  logic       wr_ok;
  assign wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_r   <= 1'b0;
      mask_r <= `PS2S_MASK_RST;
    end else if (wr_ok && wb_adr_i == `PS2S_OFS_CTRL) begin
      en_r <= wb_dat_i[`PS2S_B_EN];
    end else if (wr_ok && wb_adr_i == `PS2S_OFS_IRQ_MASK) begin
      mask_r <= wb_dat_i[7:0];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i) && $past(wb_cyc_i))
    else $error("ack without request");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  unmapped_zero_a: assert property (wb_ack_o && wb_adr_i > `PS2S_OFS_IRQ_STAT |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  open_drain_a: assert property (ps2_clk_o == 1'b0 && ps2_dat_o == 1'b0)
    else $error("line driven high");
  disabled_lines_a: assert property (!en_r && !$past(en_r) |-> ps2_clk_oe_o && !ps2_dat_oe_o)
    else $error("disabled channel lines wrong");
  masked_quiet_a: assert property (mask_r == 8'h00 && $past(mask_r) == 8'h00 |-> !irq_o)
    else $error("interrupt while masked");
  reset_state_a: assert property ($fell(rst_i) |-> ps2_clk_oe_o && !ps2_dat_oe_o && !irq_o && !wb_ack_o)
    else $error("state after reset wrong");
  rd_c: cover property (wb_ack_o && !wb_we_i);
  irq_c: cover property ($rose(irq_o));
  start_c: cover property ($rose(ps2_dat_oe_o));
  release_c: cover property ($fell(ps2_clk_oe_o) && en_r);
endmodule : ps2s_chk
bind ps2s_top ps2s_chk #(.START_CYC(START_CYC), .FRAME_CYC(FRAME_CYC)) chk_u (.*);

// ==== dv/ps2s_dev_model.sv ====
// Purpose: Behavioural PS/2 peripheral on the far side of the channel
// Assumes: Open-drain lines with pull-ups, 800 ns link clock
// Notes:   Link clock stands still high outside frames
`timescale 1ns/100ps
module ps2s_dev_model (
  // Clock
  input  wire logic clk_i,
  // Resolved line levels
  input  wire logic line_clk_i,
  input  wire logic line_dat_i,
  // Low pulls the line down
  output logic      clk_rel_o,
  output logic      dat_rel_o
);
  initial begin
    clk_rel_o = 1'b1;
    dat_rel_o = 1'b1;
  end
  task automatic pulse();
    repeat (2) @(posedge clk_i);
    clk_rel_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    clk_rel_o <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask : pulse
  // Start, data LSB first, odd parity, stop
  task automatic send(input logic [7:0] b, input logic stop_b);
    logic [10:0] f;
    f = {stop_b, ~^b, b, 1'b0};
    for (int k = 0; k < 11; k++) begin
      dat_rel_o <= f[k];
      pulse();
    end
    dat_rel_o <= 1'b1;
  endtask : send
  // Stall after pulse gap_k, or idle slow cycles after each pulse
  task automatic recv(output logic [7:0] b, output logic ok, input int gap_k, input int slow);
    int n;
    n = 0;
    b = 8'h00;
    while (!(line_clk_i === 1'b1 && line_dat_i === 1'b0) && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    ok = (n < 4000);
    for (int k = 1; k <= 11; k++) begin
      if (k == 11) dat_rel_o <= 1'b0;
      pulse();
      if (k <= 8) b[k-1] = line_dat_i;
      if (k == gap_k) repeat (3100) @(posedge clk_i);
      repeat (slow) @(posedge clk_i);
    end
    dat_rel_o <= 1'b1;
  endtask : recv
endmodule : ps2s_dev_model

// ==== dv/ps2s_top_tb.sv ====
// Purpose: Self-checking bench of the PS/2 channel status logic
// Assumes: 10 MHz clock, shortened start timeout
// Notes:   Lines are wired-AND of both parties with pull-ups
`timescale 1ns/100ps
`include "ps2s_cfg.svh"
module ps2s_top_tb;
  localparam int unsigned START_CYC = 2000;
  localparam int unsigned FRAME_CYC = 5000;
  // Per frame, LSB nibble first: stop field, sent stop level, error expected
  localparam logic [19:0] RX_TBL = 20'h8_7412;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack, clk_oe, dat_oe, irq, clk_rel, dat_rel, line_clk, line_dat, ok_b;
  logic [7:0]  got_b, byte_v;
  logic [3:0]  e;
  int          fails = 0;
  int          tests_run = 0;
  int          n;
  always #50 clk_i = ~clk_i;
  assign line_clk = !clk_oe && clk_rel;
  assign line_dat = !dat_oe && dat_rel;
  ps2s_top #(.START_CYC(START_CYC), .FRAME_CYC(FRAME_CYC)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ps2_clk_i(line_clk),
    .ps2_clk_o(), .ps2_clk_oe_o(clk_oe), .ps2_dat_i(line_dat), .ps2_dat_o(), .ps2_dat_oe_o(dat_oe), .irq_o(irq));
  ps2s_dev_model dev_u (.clk_i(clk_i), .line_clk_i(line_clk), .line_dat_i(line_dat),
    .clk_rel_o(clk_rel), .dat_rel_o(dat_rel));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(q & m, exp);
  endtask : rdc
  task automatic hold_wait();
    n = 0;
    while (clk_oe === 1'b1 && n < 6000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 6000) fails++;
  endtask : hold_wait
  task automatic final_report();
    $display("Counts: tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  initial begin
    #8_000_000;
    fails++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(`PS2S_OFS_STATUS, 32'hFFFF_FFBF, 32'h0000_0000);
    rdc(`PS2S_OFS_DATA, 32'hFFFF_FFFF, 32'h0000_00FF);
    rdc(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    chk({30'h0, clk_oe, dat_oe}, 32'h0000_0002);
    wr(`PS2S_OFS_IRQ_MASK, 32'h0000_0012);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      e = RX_TBL[4*i +: 4];
      byte_v = 8'h3C + 8'(i);
      wr(`PS2S_OFS_CTRL, {26'h0, e[3:2], 4'b0010});
      fork
        dev_u.send(byte_v, e[1]);
        begin
          repeat (40) @(posedge clk_i);
          rdc(`PS2S_OFS_STATUS, 32'h0000_0040, 32'h0000_0000);
        end
      join
      repeat (8) @(posedge clk_i);
      rdc(`PS2S_OFS_STATUS, 32'h0000_004A, e[0] ? 32'h0000_004A : 32'h0000_0040);
      rdc(`PS2S_OFS_DATA, 32'h0000_00FF, e[0] ? 32'h0000_00FF : {24'h0, byte_v});
      if (e[0]) begin
        chk({30'h0, irq, clk_oe}, 32'h0000_0003);
        hold_wait();
        wr(`PS2S_OFS_STATUS, 32'h0000_000A);
        wr(`PS2S_OFS_IRQ_STAT, 32'h0000_0002);
        @(posedge clk_i);
        rdc(`PS2S_OFS_STATUS, 32'h0000_000A, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
      end
    end
    $display("test receive done");
    wr(`PS2S_OFS_CTRL, 32'h0000_0003);
    wr(`PS2S_OFS_IRQ_STAT, 32'h0000_00FF);
    wr(`PS2S_OFS_DATA, 32'h0000_00A5);
    fork
      dev_u.recv(got_b, ok_b, 0, 0);
      rdc(`PS2S_OFS_STATUS, 32'h0000_0010, 32'h0000_0000);
    join
    chk({23'h0, ok_b, got_b}, 32'h0000_01A5);
    repeat (8) @(posedge clk_i);
    rdc(`PS2S_OFS_STATUS, 32'h0000_00B0, 32'h0000_0010);
    rdc(`PS2S_OFS_IRQ_STAT, 32'h0000_0010, 32'h0000_0010);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`PS2S_OFS_IRQ_STAT, 32'h0000_0010);
    @(posedge clk_i);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test transmit done");
    // Bit gap stall, then slow clocks exceeding the frame limit
    for (int j = 0; j < 2; j++) begin
      wr(`PS2S_OFS_DATA, 32'h0000_0077);
      rdc(`PS2S_OFS_STATUS, 32'h0000_0010, 32'h0000_0000);
      dev_u.recv(got_b, ok_b, j == 0 ? 3 : 0, j == 0 ? 0 : 700);
      rdc(`PS2S_OFS_STATUS, 32'h0000_0030, 32'h0000_0030);
      hold_wait();
      wr(`PS2S_OFS_STATUS, 32'h0000_00A0);
      wr(`PS2S_OFS_CTRL, 32'h0000_0003);
    end
    $display("test frame timeouts done");
    wr(`PS2S_OFS_IRQ_STAT, 32'h0000_00FF);
    wr(`PS2S_OFS_DATA, 32'h0000_005A);
    repeat (3300) @(posedge clk_i);
    rdc(`PS2S_OFS_STATUS, 32'h0000_00B0, 32'h0000_00B0);
    rdc(`PS2S_OFS_CTRL, 32'h0000_0001, 32'h0000_0000);
    rdc(`PS2S_OFS_IRQ_STAT, 32'h0000_0010, 32'h0000_0010);
    chk({31'h0, clk_oe}, 32'h0000_0001);
    hold_wait();
    chk({31'h0, n > 2500 && n < 6000}, 32'h0000_0001);
    wr(`PS2S_OFS_STATUS, 32'h0000_00A0);
    rdc(`PS2S_OFS_STATUS, 32'h0000_00A0, 32'h0000_0000);
    // Direction clear, then enable clear, each ends a started transmit
    for (int j = 0; j < 2; j++) begin
      wr(`PS2S_OFS_CTRL, 32'h0000_0003);
      wr(`PS2S_OFS_DATA, 32'h0000_0011);
      rdc(`PS2S_OFS_STATUS, 32'h0000_0010, 32'h0000_0000);
      wr(`PS2S_OFS_CTRL, j == 0 ? 32'h0000_0002 : 32'h0000_0001);
      rdc(`PS2S_OFS_STATUS, 32'h0000_0010, 32'h0000_0010);
    end
    repeat (3) @(posedge clk_i);
    chk({30'h0, clk_oe, dat_oe}, 32'h0000_0002);
    $display("test start timeout done");
    final_report();
  end
endmodule : ps2s_top_tb

// ==== rtl/ps2s_cfg.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the PS/2 channel status logic
// Assumes: 10 MHz core clock, word-aligned Wishbone byte addresses
// Notes:   Definitions only
`ifndef PS2S_CFG_SVH
`define PS2S_CFG_SVH

// Register byte offsets
`define PS2S_OFS_DATA      8'h00
`define PS2S_OFS_CTRL      8'h04
`define PS2S_OFS_STATUS    8'h08
`define PS2S_OFS_IRQ_MASK  8'h0C
`define PS2S_OFS_IRQ_STAT  8'h10

// Status and interrupt bit positions
`define PS2S_B_START_LATE  7
`define PS2S_B_RX_IDLE     6
`define PS2S_B_TX_WD       5
`define PS2S_B_TX_QUIET    4
`define PS2S_B_STOP_ERR    3
`define PS2S_B_RX_WD       1

// Control field positions
`define PS2S_B_DIR         0
`define PS2S_B_EN          1
`define PS2S_B_PAR_LO      2
`define PS2S_B_STOP_LO     4

// Stop level encodings
`define PS2S_STOP_HIGH     2'h0
`define PS2S_STOP_LOW      2'h1
`define PS2S_STOP_IGNORE   2'h2

// Reset values
`define PS2S_RX_DATA_RST   8'hFF
`define PS2S_STAT_RST      8'h00
`define PS2S_MASK_RST      8'h00

// Timing
`define PS2S_CLK_KHZ       10000
`define PS2S_T_BIT_US      300
`define PS2S_T_HOLD_US     300
`define PS2S_T_INHIBIT_US  100
`define PS2S_T_START_MS    25
`define PS2S_T_FRAME_MS    2
`define PS2S_BIT_CYC       ((`PS2S_T_BIT_US * `PS2S_CLK_KHZ) / 1000)
`define PS2S_HOLD_CYC      ((`PS2S_T_HOLD_US * `PS2S_CLK_KHZ + 999) / 1000)
`define PS2S_INHIBIT_CYC   ((`PS2S_T_INHIBIT_US * `PS2S_CLK_KHZ + 999) / 1000)
`define PS2S_START_CYC     (`PS2S_T_START_MS * `PS2S_CLK_KHZ)
`define PS2S_FRAME_CYC     (`PS2S_T_FRAME_MS * `PS2S_CLK_KHZ)

`endif

// ==== rtl/ps2s_edge.sv ====
// Purpose: Synchronises the PS/2 clock and data lines and finds clock falling edges
// Assumes: Line levels are asynchronous to clk_i
// Notes:   First stage is read only by the second stage
`timescale 1ns/100ps
module ps2s_edge (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Raw line levels
  input  wire logic line_clk_i,
  input  wire logic line_dat_i,
  // Synchronised view
  ps2s_if.src       lnk
);

  ps2s_pkg::ps2s_sync_t s_r;
  ps2s_pkg::ps2s_sync_t s_nxt;

  always_comb begin
    s_nxt   = s_r;
    s_nxt.m = {line_dat_i, line_clk_i};
    s_nxt.s = s_r.m;
    s_nxt.d = s_r.s[0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '{m: 2'h3, s: 2'h3, d: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lnk.clk_fall = s_r.d & ~s_r.s[0];
  assign lnk.dat_sync = s_r.s[1];

endmodule : ps2s_edge

// ==== rtl/ps2s_if.sv ====
// Purpose: Carries the synchronised link view from the edge finder to the channel logic
// Assumes: Single clock domain
// Notes:   clk_fall is a one-cycle pulse
`timescale 1ns/100ps
interface ps2s_if;
  logic clk_fall;
  logic dat_sync;
  modport src (output clk_fall, output dat_sync);
  modport dst (input clk_fall, input dat_sync);
endinterface : ps2s_if

// ==== rtl/ps2s_pkg.sv ====
// Purpose: Types of the PS/2 channel status logic
// Assumes: Constants live in ps2s_cfg.svh
// Notes:   State of each module is one packed struct
package ps2s_pkg;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_INHIBIT,
    TX_WAIT_START,
    TX_SHIFT
  } ps2s_tx_t;

  typedef struct packed {
    logic [1:0] m;
    logic [1:0] s;
    logic       d;
  } ps2s_sync_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic        en;
    logic        dir;
    logic [1:0]  par;
    logic [1:0]  stop;
    ps2s_tx_t    tx_st;
    logic [8:0]  txsh;
    logic [3:0]  txn;
    logic [3:0]  rxn;
    logic [7:0]  rxsh;
    logic [7:0]  rxd;
    logic [17:0] tmr;
    logic [14:0] frm;
    logic        start_late;
    logic        tx_wd;
    logic        tx_quiet;
    logic        stop_err;
    logic        rx_wd;
    logic        hold;
    logic        hold_seen;
    logic [11:0] hcnt;
    logic [7:0]  ist;
    logic [7:0]  imask;
    logic        irq;
    logic        clk_oe;
    logic        dat_oe;
  } ps2s_state_t;

endpackage : ps2s_pkg

// ==== rtl/ps2s_top.sv ====
// Purpose: Status, timeout and framing-error logic of one PS/2 channel, Wishbone slave
// Assumes: 10 MHz clk_i, synchronous active-high reset, open-drain PS/2 lines
// Notes:   Operation
`timescale 1ns/100ps
`include "ps2s_cfg.svh"
module ps2s_top #(
  parameter int unsigned START_CYC = `PS2S_START_CYC,
  parameter int unsigned FRAME_CYC = `PS2S_FRAME_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // PS/2 clock line
  input  wire logic        ps2_clk_i,
  output logic             ps2_clk_o,
  output logic             ps2_clk_oe_o,
  // PS/2 data line
  input  wire logic        ps2_dat_i,
  output logic             ps2_dat_o,
  output logic             ps2_dat_oe_o,
  // Interrupt
  output logic             irq_o
);

  localparam logic [17:0] BIT_CYC = 18'(`PS2S_BIT_CYC);
  localparam logic [11:0] HOLD_CYC = 12'(`PS2S_HOLD_CYC);
  localparam logic [17:0] INH_CYC = 18'(`PS2S_INHIBIT_CYC);
  localparam logic [17:0] START_LIM = 18'(START_CYC - 1);
  localparam logic [14:0] FRAME_LIM = 15'(FRAME_CYC);

  ps2s_pkg::ps2s_state_t s_r;
  ps2s_pkg::ps2s_state_t s_nxt;

  ps2s_if u_lnk ();

  ps2s_edge u_edge (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .line_clk_i (ps2_clk_i),
    .line_dat_i (ps2_dat_i),
    .lnk        (u_lnk.src)
  );

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction : hit

  function automatic logic [7:0] status_byte(input ps2s_pkg::ps2s_state_t st);
    logic [7:0] v;
    v                      = `PS2S_STAT_RST;
    v[`PS2S_B_START_LATE]  = st.start_late;
    v[`PS2S_B_RX_IDLE]     = (st.rxn == 4'h0);
    v[`PS2S_B_TX_WD]       = st.tx_wd;
    v[`PS2S_B_TX_QUIET]    = st.tx_quiet;
    v[`PS2S_B_STOP_ERR]    = st.stop_err;
    v[`PS2S_B_RX_WD]       = st.rx_wd;
    status_byte            = v;
  endfunction : status_byte

  always_comb begin
    logic       acc;
    logic       wr;
    logic       rd;
    logic       wr_ctrl;
    logic       rd_stat;
    logic       tx_go;
    logic       fall;
    logic       din;
    logic [3:0] cnt;
    logic [7:0] w1c;
    logic [7:0] iclr;
    logic       ev_start;
    logic       ev_txwd;
    logic       ev_stop;
    logic       ev_rxwd;
    logic       ev_quiet;
    logic       tx_done;
    logic       en_drop;
    logic       dir_drop;

    s_nxt    = s_r;
    fall     = u_lnk.clk_fall;
    din      = u_lnk.dat_sync;
    cnt      = 4'h0;
    ev_start = 1'b0;
    ev_txwd  = 1'b0;
    ev_stop  = 1'b0;
    ev_rxwd  = 1'b0;
    tx_done  = 1'b0;

    // Bus: ack one cycle after the request, commit at the edge that samples it
    s_nxt.ack = wb_cyc_i & wb_stb_i & ~s_r.ack;
    acc       = wb_cyc_i & wb_stb_i & s_r.ack;
    wr        = acc & wb_we_i & wb_sel_i[0];
    rd        = acc & ~wb_we_i;
    wr_ctrl   = wr & hit(wb_adr_i, `PS2S_OFS_CTRL);
    rd_stat   = rd & hit(wb_adr_i, `PS2S_OFS_STATUS);
    tx_go     = wr & hit(wb_adr_i, `PS2S_OFS_DATA);
    w1c       = (wr & hit(wb_adr_i, `PS2S_OFS_STATUS)) ? wb_dat_i[7:0] : 8'h00;
    iclr      = (wr & hit(wb_adr_i, `PS2S_OFS_IRQ_STAT)) ? wb_dat_i[7:0] : 8'h00;

    if (wr_ctrl) begin
      s_nxt.dir  = wb_dat_i[`PS2S_B_DIR];
      s_nxt.en   = wb_dat_i[`PS2S_B_EN];
      s_nxt.par  = wb_dat_i[`PS2S_B_PAR_LO +: 2];
      s_nxt.stop = wb_dat_i[`PS2S_B_STOP_LO +: 2];
    end
    if (wr & hit(wb_adr_i, `PS2S_OFS_IRQ_MASK)) begin
      s_nxt.imask = wb_dat_i[7:0];
    end
    // Reading the receive data reloads the empty pattern
    if (rd & hit(wb_adr_i, `PS2S_OFS_DATA)) begin
      s_nxt.rxd = `PS2S_RX_DATA_RST;
    end
    en_drop  = s_r.en & ~s_nxt.en;
    dir_drop = s_r.dir & ~s_nxt.dir;

    // Transmit sequencer
    case (s_r.tx_st)
      ps2s_pkg::TX_IDLE: begin
        s_nxt.dat_oe = 1'b0;
        if (tx_go && s_r.en && s_r.dir && !s_r.tx_wd && !s_r.hold && s_r.rxn == 4'h0) begin
          s_nxt.tx_st = ps2s_pkg::TX_INHIBIT;
          s_nxt.tmr   = 18'h0_0000;
          s_nxt.txsh  = {~^wb_dat_i[7:0], wb_dat_i[7:0]};
        end
      end
      ps2s_pkg::TX_INHIBIT: begin
        s_nxt.tmr = s_r.tmr + 18'h0_0001;
        if (s_r.tmr >= INH_CYC - 18'h0_0001) begin
          s_nxt.tx_st  = ps2s_pkg::TX_WAIT_START;
          s_nxt.tmr    = 18'h0_0000;
          s_nxt.dat_oe = 1'b1;
        end
      end
      ps2s_pkg::TX_WAIT_START: begin
        s_nxt.tmr = s_r.tmr + 18'h0_0001;
        if (fall) begin
          s_nxt.tx_st  = ps2s_pkg::TX_SHIFT;
          s_nxt.txn    = 4'h1;
          s_nxt.tmr    = 18'h0_0000;
          s_nxt.frm    = 15'h0000;
          s_nxt.dat_oe = ~s_r.txsh[0];
          s_nxt.txsh   = {1'b1, s_r.txsh[8:1]};
        end else if (s_r.tmr >= START_LIM) begin
          ev_start = 1'b1;
          ev_txwd  = 1'b1;
        end
      end
      ps2s_pkg::TX_SHIFT: begin
        s_nxt.tmr = s_r.tmr + 18'h0_0001;
        s_nxt.frm = (s_r.frm == 15'h7FFF) ? s_r.frm : s_r.frm + 15'h0001;
        if (fall) begin
          cnt       = s_r.txn + 4'h1;
          s_nxt.txn = cnt;
          s_nxt.tmr = 18'h0_0000;
          if (cnt <= 4'h9) begin
            s_nxt.dat_oe = ~s_r.txsh[0];
            s_nxt.txsh   = {1'b1, s_r.txsh[8:1]};
          end else begin
            s_nxt.dat_oe = 1'b0;
          end
          if (cnt == 4'hA && s_r.frm > FRAME_LIM) begin
            ev_txwd = 1'b1;
          end
          if (cnt == 4'hB) begin
            tx_done = 1'b1;
          end
        end else if (s_r.tmr >= BIT_CYC) begin
          ev_txwd = 1'b1;
        end else if (s_r.txn < 4'hA && s_r.frm > FRAME_LIM) begin
          ev_txwd = 1'b1;
        end
      end
      default: begin
        s_nxt.tx_st = ps2s_pkg::TX_IDLE;
      end
    endcase

    if (tx_done || ev_txwd || !s_nxt.en || !s_nxt.dir) begin
      s_nxt.tx_st  = ps2s_pkg::TX_IDLE;
      s_nxt.txn    = 4'h0;
      s_nxt.dat_oe = 1'b0;
    end

    // Receiver: active only when enabled, receiving and not holding the clock
    if (!s_r.en || s_r.dir || s_r.hold || s_r.tx_st != ps2s_pkg::TX_IDLE) begin
      s_nxt.rxn = 4'h0;
    end else if (fall) begin
      cnt       = s_r.rxn + 4'h1;
      s_nxt.rxn = cnt;
      if (s_r.rxn != 4'h0) begin
        s_nxt.tmr = 18'h0_0000;
      end
      if (cnt == 4'h1) begin
        s_nxt.tmr = 18'h0_0000;
        s_nxt.frm = 15'h0000;
      end else if (cnt <= 4'h9) begin
        s_nxt.rxsh = {din, s_r.rxsh[7:1]};
      end else if (cnt == 4'hA) begin
        ev_rxwd = (s_r.frm > FRAME_LIM);
      end else begin
        s_nxt.rxn = 4'h0;
        case (s_r.stop)
          `PS2S_STOP_HIGH: ev_stop = ~din;
          `PS2S_STOP_LOW:  ev_stop = din;
          default:         ev_stop = 1'b0;
        endcase
        if (!ev_stop) begin
          s_nxt.rxd = s_r.rxsh;
        end
      end
    end else if (s_r.rxn != 4'h0) begin
      s_nxt.tmr = s_r.tmr + 18'h0_0001;
      s_nxt.frm = (s_r.frm == 15'h7FFF) ? s_r.frm : s_r.frm + 15'h0001;
      if (s_r.tmr >= BIT_CYC || (s_r.rxn < 4'hA && s_r.frm > FRAME_LIM)) begin
        ev_rxwd   = 1'b1;
        s_nxt.rxn = 4'h0;
      end
    end
    if (ev_rxwd || ev_stop) begin
      s_nxt.rxn = 4'h0;
      s_nxt.rxd = `PS2S_RX_DATA_RST;
    end

    // Sticky flags: a set in the same cycle as a write-one clear wins
    s_nxt.start_late = (s_r.start_late & ~w1c[`PS2S_B_START_LATE]) | ev_start;
    s_nxt.tx_wd      = (s_r.tx_wd & ~w1c[`PS2S_B_TX_WD]) | ev_txwd;
    s_nxt.stop_err   = (s_r.stop_err & ~w1c[`PS2S_B_STOP_ERR]) | ev_stop;
    s_nxt.rx_wd      = (s_r.rx_wd & ~w1c[`PS2S_B_RX_WD]) | ev_stop | ev_rxwd;

    // Direction forced clear while the transmit timeout stands
    if (s_nxt.tx_wd) begin
      s_nxt.dir = 1'b0;
    end

    // Transmitter idle indicator
    if (tx_go) begin
      s_nxt.tx_quiet = 1'b0;
    end
    if (tx_done || ev_txwd || en_drop || dir_drop || (s_r.dir && !s_nxt.dir)) begin
      s_nxt.tx_quiet = 1'b1;
    end
    ev_quiet = s_nxt.tx_quiet & ~s_r.tx_quiet;

    // Clock hold after a timeout or stop error: minimum time, then until the status is read
    if (ev_txwd || ev_rxwd || ev_stop) begin
      s_nxt.hold      = 1'b1;
      s_nxt.hold_seen = 1'b0;
      s_nxt.hcnt      = 12'h000;
    end else if (s_r.hold) begin
      if (s_r.hcnt < HOLD_CYC) begin
        s_nxt.hcnt = s_r.hcnt + 12'h001;
      end
      s_nxt.hold_seen = s_r.hold_seen | rd_stat;
      if (s_r.hcnt >= HOLD_CYC && (s_r.hold_seen || rd_stat)) begin
        s_nxt.hold = 1'b0;
      end
    end

    // Line drive: disabled or holding pulls clock low, data released
    s_nxt.clk_oe = ~s_nxt.en | s_nxt.hold | (s_nxt.tx_st == ps2s_pkg::TX_INHIBIT);
    if (!s_nxt.en) begin
      s_nxt.dat_oe = 1'b0;
    end

    // Interrupt status
    s_nxt.ist = s_r.ist & ~iclr;
    s_nxt.ist[`PS2S_B_START_LATE] = s_nxt.ist[`PS2S_B_START_LATE] | ev_start;
    s_nxt.ist[`PS2S_B_TX_WD]      = s_nxt.ist[`PS2S_B_TX_WD] | ev_txwd;
    s_nxt.ist[`PS2S_B_TX_QUIET]   = s_nxt.ist[`PS2S_B_TX_QUIET] | ev_quiet;
    s_nxt.ist[`PS2S_B_STOP_ERR]   = s_nxt.ist[`PS2S_B_STOP_ERR] | ev_stop;
    s_nxt.ist[`PS2S_B_RX_WD]      = s_nxt.ist[`PS2S_B_RX_WD] | ev_rxwd | ev_stop;
    s_nxt.irq = |(s_nxt.ist & s_nxt.imask);

    // Read data, loaded with the ack
    s_nxt.dat = 32'h0000_0000;
    if (s_nxt.ack) begin
      if (hit(wb_adr_i, `PS2S_OFS_DATA)) begin
        s_nxt.dat[7:0] = s_r.rxd;
      end else if (hit(wb_adr_i, `PS2S_OFS_CTRL)) begin
        s_nxt.dat[5:0] = {s_r.stop, s_r.par, s_r.en, s_r.dir};
      end else if (hit(wb_adr_i, `PS2S_OFS_STATUS)) begin
        s_nxt.dat[7:0] = status_byte(s_r);
      end else if (hit(wb_adr_i, `PS2S_OFS_IRQ_MASK)) begin
        s_nxt.dat[7:0] = s_r.imask;
      end else if (hit(wb_adr_i, `PS2S_OFS_IRQ_STAT)) begin
        s_nxt.dat[7:0] = s_r.ist;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r            <= '0;
      s_r.tx_st      <= ps2s_pkg::TX_IDLE;
      s_r.rxd        <= `PS2S_RX_DATA_RST;
      s_r.imask      <= `PS2S_MASK_RST;
      s_r.txsh       <= 9'h1FF;
      s_r.clk_oe     <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o     = s_r.dat;
  assign wb_ack_o     = s_r.ack;
  assign ps2_clk_o    = 1'b0;
  assign ps2_clk_oe_o = s_r.clk_oe;
  assign ps2_dat_o    = 1'b0;
  assign ps2_dat_oe_o = s_r.dat_oe;
  assign irq_o        = s_r.irq;

endmodule : ps2s_top
